/* src/twu_map.vh */
`ifndef TWU_MAP_VH
`define TWU_MAP_VH
// Register byte offsets
`define TWU_OFF_CFG      4'h0
`define TWU_OFF_PRESC    4'h1
`define TWU_OFF_RELOAD   4'h2
`define TWU_OFF_TCS      4'h3
`define TWU_OFF_PRESET   4'h4
`define TWU_OFF_MATCH    4'h5
// Configuration field positions
`define TWU_CFG_CFGLK    0
`define TWU_CFG_PSLK     1
`define TWU_CFG_TMLK     2
`define TWU_CFG_PRLK     3
`define TWU_CFG_CLKSEL   4
`define TWU_CFG_DMM      5
`define TWU_CFG_RSTKIND  6
`define TWU_CFG_C2POR    7
// Timer control/status field positions
`define TWU_TCS_RESTART  0
`define TWU_TCS_TC       1
`define TWU_TCS_PEND     3
`define TWU_TCS_EVT      4
`define TWU_TCS_RUN      5
// Reset values
`define TWU_RST_RELOAD   16'hFFFF
`define TWU_RST_PRESET   8'h0F
`define TWU_RST_EXP      3'h0
// Match-port bytes
`define TWU_SERVICE_BYTE 8'h5C
`define TWU_SEQ_BYTE0    8'h87
`define TWU_SEQ_BYTE1    8'h61
`define TWU_SEQ_BYTE2    8'h63
// Timing
`define TWU_MAX_EXP      3'h5
`define TWU_EARLY_TICKS  2'h3
`define TWU_POR_CYCLES   8'h10
`endif

/* src/twu_prescaler.v */
`timescale 1ns/1ps
`include "twu_map.vh"
module twu_prescaler
(
  // Clock and reset
  input  wire       CLK,
  input  wire       RST_B,
  // Control
  input  wire       lf_tick,
  input  wire [2:0] exponent,
  // Output
  output reg        prescaled_tick
);
  reg  [4:0] div_count;
  reg  [4:0] limit;
  wire [2:0] eff_exp;

  assign eff_exp = (exponent > `TWU_MAX_EXP) ? `TWU_MAX_EXP : exponent;

  always @*
  begin
    limit = (5'h1 << eff_exp) - 5'h1;
  end

  // One tick per 2^exponent low-frequency cycles, exponent capped at 5 [R1]
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      div_count      <= 5'h00;
      prescaled_tick <= 1'b0;
    end
    else
    begin
      prescaled_tick <= 1'b0;
      if (lf_tick)
      begin
        if (div_count >= limit)
        begin
          div_count      <= 5'h00;
          prescaled_tick <= 1'b1;
        end
        else
          div_count <= div_count + 5'h01;
      end
    end
  end
endmodule // twu_prescaler

/* src/twu_timer.v */
`timescale 1ns/1ps
`include "twu_map.vh"
module twu_timer
(
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_B,
  // Control
  input  wire        tick,
  input  wire [15:0] reload,
  input  wire        restart,
  // Outputs
  output reg  [15:0] count,
  output reg         terminal
);
  // Counts down on ticks, reloads after zero [R2]
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      count    <= `TWU_RST_RELOAD;
      terminal <= 1'b0;
    end
    else if (tick)
    begin
      if (restart)
      begin
        count    <= reload; // [R6]
        terminal <= 1'b0;
      end
      else if (count == 16'h0000)
      begin
        count    <= reload; // [R5]
        terminal <= 1'b0;
      end
      else
      begin
        count    <= count - 16'h0001;
        terminal <= (count == 16'h0001); // [R3]
      end
    end
  end
endmodule // twu_timer

/* src/twu_top.v */
// Contract
// R1 - Prescaler divides by two to exponent
// R2 - Sixteen-bit timer counts down, auto reloads
// R3 - Terminal pulse high one prescaled cycle
// R4 - Terminal pulse goes to wakeup, interrupt
// R5 - New reload applies after reaching zero
// R6 - Restart bit forces reload, self clears
// R7 - Eight-bit watchdog, stopped after reset
// R8 - Preset write or service byte starts
// R9 - Only reset, warm reset, stop halt it
// R10 - Preset write touches; lock reuses preset
// R11 - Match mode: service byte touches
// R12 - Reaching zero raises an event
// R13 - Service within three clocks raises event
// R14 - Wrong match byte raises event
// R15 - Three-byte sequence stops watchdog
// R16 - Run status bit shows running
// R17 - Sequence while stopped clears locks
// R18 - Clock select: pulse or prescaled tick
// R19 - Event routes to cold or warm reset
// R20 - Event flag survives resulting reset
// R21 - Lock bits block protected writes
// R22 - Pending flag until writes applied
`timescale 1ns/1ps
`include "twu_map.vh"
module twu_top
#(
  parameter LF_DIV = 6104
)
(
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        POR_RST_B,
  // Avalon-MM slave
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  // System outputs
  output wire        TIMER_TERMINAL_PULSE,
  output wire        WAKEUP_TICK,
  output wire        INTERRUPT_TICK,
  output reg         WDOG_COLD_RESET,
  output reg         WDOG_WARM_RESET,
  output reg         POR_PULSE
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK  = 2'b10;

  reg  [1:0]  bus_state;
  reg  [12:0] lf_count;
  reg         lf_tick;
  reg  [7:0]  cfg;
  reg  [2:0]  prescale_exponent;
  reg  [15:0] timer_reload_value;
  reg         restart_req;
  reg         tc_flag;
  reg  [7:0]  watchdog_preset;
  reg  [7:0]  wd_count;
  reg         watchdog_running;
  reg         watchdog_event_flag;
  reg  [1:0]  seq_pos;
  reg  [1:0]  early_count;
  reg         serviced;
  reg  [1:0]  pend_lf;
  reg         write_pending_flag;
  reg  [7:0]  por_count;
  reg         wd_event;
  wire        prescaled_tick;
  wire        timer_terminal_pulse;
  wire [15:0] timer_count;
  wire        wd_clk;
  wire        acc;
  wire        wr;
  wire [7:0]  wbyte;
  wire        wr_preset;
  wire        wr_match;
  wire        seq_ok;
  wire        seq_done;
  wire        touch;
  wire        early_hit;
  wire        bad_byte;
  wire        late_hit;
  wire        rd_cap;

  function is_seq;
    input [1:0] pos;
    input [7:0] b;
    begin
      is_seq = (pos == 2'd0 && b == `TWU_SEQ_BYTE0) ||
               (pos == 2'd1 && b == `TWU_SEQ_BYTE1) ||
               (pos == 2'd2 && b == `TWU_SEQ_BYTE2);
    end
  endfunction

  // One-wait-state answer: request taken on the ACK cycle
  assign acc             = (AVS_READ | AVS_WRITE) & (bus_state == ST_ACK);
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (bus_state != ST_ACK);
  assign wr              = acc & AVS_WRITE;
  assign wbyte           = AVS_WRITEDATA[7:0];
  assign wr_preset       = wr & (AVS_ADDRESS == `TWU_OFF_PRESET);
  assign wr_match        = wr & (AVS_ADDRESS == `TWU_OFF_MATCH);
  assign seq_ok          = wr_match & is_seq(seq_pos, wbyte);
  assign seq_done        = seq_ok & (seq_pos == 2'd2);
  // Read data latched in the first cycle, standing when waitrequest drops
  assign rd_cap          = AVS_READ & (bus_state == ST_IDLE);

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      bus_state <= ST_IDLE;
    else
    begin
      case (bus_state)
        ST_IDLE: if (AVS_READ | AVS_WRITE) bus_state <= ST_ACK;
        ST_ACK:  bus_state <= ST_IDLE;
        default: bus_state <= ST_IDLE;
      endcase
    end
  end

  // 32.768 kHz tick derived from the system clock
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lf_count <= 13'h0000;
      lf_tick  <= 1'b0;
    end
    else if (lf_count >= LF_DIV[12:0] - 13'h0001)
    begin
      lf_count <= 13'h0000;
      lf_tick  <= 1'b1;
    end
    else
    begin
      lf_count <= lf_count + 13'h0001;
      lf_tick  <= 1'b0;
    end
  end

  twu_prescaler u_presc
  (
    .CLK            (CLK),
    .RST_B          (RST_B),
    .lf_tick        (lf_tick),
    .exponent       (prescale_exponent),
    .prescaled_tick (prescaled_tick)
  );

  twu_timer u_timer
  (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .tick     (prescaled_tick),
    .reload   (timer_reload_value),
    .restart  (restart_req),
    .count    (timer_count),
    .terminal (timer_terminal_pulse)
  );

  // Terminal pulse fans out to wakeup and interrupt units [R4]
  assign TIMER_TERMINAL_PULSE = timer_terminal_pulse;
  assign WAKEUP_TICK          = timer_terminal_pulse & prescaled_tick;
  assign INTERRUPT_TICK       = timer_terminal_pulse & prescaled_tick;

  // Watchdog clock: pulse start or prescaled tick [R18]
  assign wd_clk = cfg[`TWU_CFG_CLKSEL] ? prescaled_tick :
                  (prescaled_tick & timer_count == 16'h0001);

  // Touch per mode; preset writes count even when locked [R10] [R11]
  assign touch = (wr_preset & !watchdog_running) | // [R8]
                 (cfg[`TWU_CFG_DMM] ?
                  (wr_match & wbyte == `TWU_SERVICE_BYTE) : wr_preset);
  assign early_hit = watchdog_running & serviced &
                     (wr_preset | (wr_match & wbyte == `TWU_SERVICE_BYTE &
                                   cfg[`TWU_CFG_DMM])) &
                     (early_count < `TWU_EARLY_TICKS); // [R13]
  assign bad_byte  = watchdog_running & cfg[`TWU_CFG_DMM] & wr_match &
                     wbyte != `TWU_SERVICE_BYTE & !seq_ok; // [R14] [R15]
  assign late_hit  = watchdog_running & wd_clk &
                     (wd_count == 8'h01); // [R12]

  always @*
  begin
    wd_event = early_hit | bad_byte | late_hit;
  end

  // Configuration and locking
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cfg                <= 8'h00;
      prescale_exponent  <= `TWU_RST_EXP;
      timer_reload_value <= `TWU_RST_RELOAD;
      restart_req        <= 1'b0;
      tc_flag            <= 1'b0;
      watchdog_preset    <= `TWU_RST_PRESET;
      seq_pos            <= 2'd0;
    end
    else
    begin
      if (wr_match)
        seq_pos <= seq_done ? 2'd0 : (seq_ok ? seq_pos + 2'd1 : 2'd0);
      if (seq_done & !watchdog_running)
        cfg[3:0] <= 4'h0; // [R17]
      else if (wr & AVS_ADDRESS == `TWU_OFF_CFG & !cfg[`TWU_CFG_CFGLK])
      begin
        cfg[7:4] <= wbyte[7:4]; // [R21]
        cfg[3:0] <= cfg[3:0] | wbyte[3:0];
      end
      if (wr & AVS_ADDRESS == `TWU_OFF_PRESC & !cfg[`TWU_CFG_PSLK])
        prescale_exponent <= wbyte[2:0]; // [R21]
      if (wr & AVS_ADDRESS == `TWU_OFF_RELOAD & !cfg[`TWU_CFG_TMLK])
        timer_reload_value <= AVS_WRITEDATA[15:0]; // [R5] [R21]
      // Software set wins over the tick's clear, so no request is lost
      if (wr & AVS_ADDRESS == `TWU_OFF_TCS & !cfg[`TWU_CFG_TMLK] &
          wbyte[`TWU_TCS_RESTART])
        restart_req <= 1'b1; // [R6]
      else if (prescaled_tick)
        restart_req <= 1'b0; // [R6]
      if (prescaled_tick & timer_count == 16'h0001)
        tc_flag <= 1'b1;
      else if (rd_cap & AVS_ADDRESS == `TWU_OFF_TCS)
        tc_flag <= 1'b0;
      if (wr_preset & !cfg[`TWU_CFG_PRLK])
        watchdog_preset <= wbyte; // [R10] [R21]
    end
  end

  // Watchdog counter
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wd_count         <= `TWU_RST_PRESET;
      watchdog_running <= 1'b0; // [R7]
      early_count      <= 2'd0;
      serviced         <= 1'b0;
    end
    else if (wd_event)
    begin
      // A stop sequence ending with a late event still stops it
      watchdog_running <= (cfg[`TWU_CFG_RSTKIND] | seq_done) ?
                          1'b0 : watchdog_running; // [R9] [R15]
      serviced         <= 1'b0;
    end
    else if (seq_done & watchdog_running)
      watchdog_running <= 1'b0; // [R15] [R9]
    else if (touch)
    begin
      wd_count <= (wr_preset & !cfg[`TWU_CFG_PRLK]) ?
                  wbyte : watchdog_preset; // [R8] [R10]
      watchdog_running <= 1'b1; // [R8]
      early_count      <= 2'd0;
      serviced         <= 1'b1;
    end
    else if (watchdog_running & wd_clk)
    begin
      wd_count <= wd_count - 8'h01; // [R7]
      if (early_count != `TWU_EARLY_TICKS)
        early_count <= early_count + 2'd1;
    end
  end

  // Pending flag set by prescaler, reload and preset writes, cleared on the third low-frequency tick [R22]
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pend_lf            <= 2'd0;
      write_pending_flag <= 1'b0;
    end
    else if (wr & (AVS_ADDRESS == `TWU_OFF_PRESC |
                   AVS_ADDRESS == `TWU_OFF_RELOAD | wr_preset))
    begin
      write_pending_flag <= 1'b1;
      pend_lf            <= 2'd0;
    end
    else if (lf_tick & write_pending_flag)
    begin
      if (pend_lf == 2'd2)
        write_pending_flag <= 1'b0;
      pend_lf <= pend_lf + 2'd1;
    end
  end

  // Event flag on power-on reset only, so it survives [R20]
  always @(posedge CLK or negedge POR_RST_B)
  begin
    if (!POR_RST_B)
      watchdog_event_flag <= 1'b0;
    else if (wd_event)
      watchdog_event_flag <= 1'b1;
    else if (wr & AVS_ADDRESS == `TWU_OFF_TCS & wbyte[`TWU_TCS_EVT])
      watchdog_event_flag <= 1'b0;
  end

  // Reset routing [R19]
  always @(posedge CLK or negedge POR_RST_B)
  begin
    if (!POR_RST_B)
    begin
      WDOG_COLD_RESET <= 1'b0;
      WDOG_WARM_RESET <= 1'b0;
      POR_PULSE       <= 1'b0;
      por_count       <= 8'h00;
    end
    else
    begin
      WDOG_COLD_RESET <= wd_event & !cfg[`TWU_CFG_RSTKIND];
      WDOG_WARM_RESET <= wd_event & cfg[`TWU_CFG_RSTKIND];
      if (wd_event & !cfg[`TWU_CFG_RSTKIND] & cfg[`TWU_CFG_C2POR])
        por_count <= `TWU_POR_CYCLES;
      else if (por_count != 8'h00)
        por_count <= por_count - 8'h01;
      POR_PULSE <= (por_count != 8'h00);
    end
  end

  // Read mux
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      AVS_READDATA <= 32'h00000000;
    else if (rd_cap)
    begin
      if (AVS_ADDRESS == `TWU_OFF_CFG)
        AVS_READDATA <= {24'h000000, cfg};
      else if (AVS_ADDRESS == `TWU_OFF_PRESC)
        AVS_READDATA <= {29'h0, prescale_exponent};
      else if (AVS_ADDRESS == `TWU_OFF_RELOAD)
        AVS_READDATA <= {16'h0000, timer_reload_value};
      else if (AVS_ADDRESS == `TWU_OFF_TCS)
        AVS_READDATA <= {26'h0, watchdog_running, // [R16]
                         watchdog_event_flag, write_pending_flag,
                         1'b0, tc_flag, restart_req};
      else
        AVS_READDATA <= 32'h00000000;
    end
  end
endmodule // twu_top

/* testbench/twu_top_asserts.sv */
`timescale 1ns/1ps
module twu_top_asserts
#(
  parameter LF_DIV = 6104
)
(
  input wire        CLK,
  input wire        RST_B,
  input wire        POR_RST_B,
  input wire [3:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire        TIMER_TERMINAL_PULSE,
  input wire        WAKEUP_TICK,
  input wire        INTERRUPT_TICK,
  input wire        WDOG_COLD_RESET,
  input wire        WDOG_WARM_RESET,
  input wire        POR_PULSE
);
  wire      req = AVS_READ | AVS_WRITE;
  wire      rst_n = RST_B & POR_RST_B;
  reg [4:0] since_cold;
  // Cycles since the last cold reset pulse, saturating
  always @(posedge CLK or negedge rst_n)
    if (!rst_n)
      since_cold <= 5'h1F;
    else if (WDOG_COLD_RESET)
      since_cold <= 5'h00;
    else if (since_cold != 5'h1F)
      since_cold <= since_cold + 5'h01;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B || !POR_RST_B);
  a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
    else $error("waitrequest low in first request cycle");
  a_wait_second: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest held past second cycle");
  a_rdata_hold: assert property (!AVS_READ && !$past(AVS_READ)
    |-> $stable(AVS_READDATA)) else $error("read data changed without read");
  a_tick_pair: assert property (WAKEUP_TICK == INTERRUPT_TICK)
    else $error("wakeup and interrupt ticks differ");
  a_tick_one: assert property (WAKEUP_TICK |=> !WAKEUP_TICK)
    else $error("wakeup tick longer than one cycle");
  a_tick_in_term: assert property
    (WAKEUP_TICK |-> TIMER_TERMINAL_PULSE)
    else $error("wakeup tick outside terminal period");
  a_cold_one: assert property (WDOG_COLD_RESET |=> !WDOG_COLD_RESET)
    else $error("cold reset pulse too long");
  a_warm_one: assert property (WDOG_WARM_RESET |=> !WDOG_WARM_RESET)
    else $error("warm reset pulse too long");
  a_kinds_apart: assert property (!(WDOG_COLD_RESET && WDOG_WARM_RESET))
    else $error("cold and warm reset together");
  a_por_cause: assert property ($rose(POR_PULSE) |-> since_cold <= 5'd20)
    else $error("power-on pulse without cold reset");
endmodule // twu_top_asserts

bind twu_top twu_top_asserts #(.LF_DIV(LF_DIV)) u_twu_top_asserts
(
  .CLK                  (CLK),
  .RST_B                (RST_B),
  .POR_RST_B            (POR_RST_B),
  .AVS_ADDRESS          (AVS_ADDRESS),
  .AVS_READ             (AVS_READ),
  .AVS_WRITE            (AVS_WRITE),
  .AVS_WRITEDATA        (AVS_WRITEDATA),
  .AVS_READDATA         (AVS_READDATA),
  .AVS_WAITREQUEST      (AVS_WAITREQUEST),
  .TIMER_TERMINAL_PULSE (TIMER_TERMINAL_PULSE),
  .WAKEUP_TICK          (WAKEUP_TICK),
  .INTERRUPT_TICK       (INTERRUPT_TICK),
  .WDOG_COLD_RESET      (WDOG_COLD_RESET),
  .WDOG_WARM_RESET      (WDOG_WARM_RESET),
  .POR_PULSE            (POR_PULSE)
);

/* testbench/twu_top_test.sv */
`timescale 1ns/1ps
module twu_top_test;
  localparam LF = 4;
  reg         CLK, RST_B, POR_RST_B, AVS_READ, AVS_WRITE;
  reg  [3:0]  AVS_ADDRESS;
  reg  [31:0] AVS_WRITEDATA, seed, rd;
  wire [31:0] AVS_READDATA;
  wire        AVS_WAITREQUEST, TIMER_TERMINAL_PULSE, WAKEUP_TICK;
  wire        INTERRUPT_TICK, WDOG_COLD_RESET, WDOG_WARM_RESET, POR_PULSE;
  integer     bad_count, num_checks, n, e, r, a;

  twu_top #(.LF_DIV(LF)) u_twu_top
  (
    .CLK                  (CLK),
    .RST_B                (RST_B),
    .POR_RST_B            (POR_RST_B),
    .AVS_ADDRESS          (AVS_ADDRESS),
    .AVS_READ             (AVS_READ),
    .AVS_WRITE            (AVS_WRITE),
    .AVS_WRITEDATA        (AVS_WRITEDATA),
    .AVS_READDATA         (AVS_READDATA),
    .AVS_WAITREQUEST      (AVS_WAITREQUEST),
    .TIMER_TERMINAL_PULSE (TIMER_TERMINAL_PULSE),
    .WAKEUP_TICK          (WAKEUP_TICK),
    .INTERRUPT_TICK       (INTERRUPT_TICK),
    .WDOG_COLD_RESET      (WDOG_COLD_RESET),
    .WDOG_WARM_RESET      (WDOG_WARM_RESET),
    .POR_PULSE            (POR_PULSE)
  );

  function [31:0] rnd;
    input integer dummy;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction

  task end_sim;
    begin
      if (bad_count == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task bus(input w, input [3:0] adr, input [31:0] d);
    integer i;
    begin
      @(posedge CLK);
      AVS_ADDRESS <= adr;
      AVS_WRITEDATA <= d;
      AVS_READ <= !w;
      AVS_WRITE <= w;
      i = 0;
      @(negedge CLK);
      while (AVS_WAITREQUEST !== 1'b0 && i < 50)
      begin
        @(negedge CLK);
        i = i + 1;
      end
      @(posedge CLK);
      rd = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      if (i >= 50)
      begin
        bad_count = bad_count + 1;
        end_sim;
      end
    end
  endtask

  task wr(input [3:0] adr, input [31:0] d);
    bus(1'b1, adr, d);
  endtask

  task rdr(input [3:0] adr);
    bus(1'b0, adr, 32'h0);
  endtask

  // Cycles until the chosen output is high; quiet means none is expected
  task wait_sig(input integer which, input integer lim, input quiet);
    begin
      n = 0;
      do
      begin
        @(negedge CLK);
        n = n + 1;
      end
      while ((which == 0 ? WAKEUP_TICK : which == 1 ? WDOG_COLD_RESET :
              which == 2 ? WDOG_WARM_RESET : POR_PULSE) !== 1'b1 && n < lim);
      if (n >= lim && !quiet)
      begin
        bad_count = bad_count + 1;
        end_sim;
      end
    end
  endtask

  task stop_seq;
    begin
      wr(4'h5, 32'h87);
      wr(4'h5, 32'h61);
      wr(4'h5, 32'h63);
    end
  endtask

  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  initial
  begin
    {RST_B, POR_RST_B, AVS_READ, AVS_WRITE} = 4'h0;
    AVS_ADDRESS = 4'h0;
    AVS_WRITEDATA = 32'h0;
    seed = 32'hCD5A;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    POR_RST_B <= 1'b1;
    rdr(4'h2); chk(rd, 32'hFFFF);
    rdr(4'h0); chk(rd, 32'h0);
    rdr(4'h3); chk(rd, 32'h0);
    for (a = 6; a < 16; a = a + 1)
    begin
      rdr(a[3:0]); chk(rd, 32'h0);
    end
    for (e = 0; e < 6; e = e + 1)
    begin
      r = 2 + rnd(0) % 4;
      wr(4'h1, e);
      wr(4'h2, r);
      repeat (20) @(posedge CLK);
      wr(4'h3, 32'h1);
      wait_sig(0, 3000, 1'b0);
      wait_sig(0, 3000, 1'b0);
      wait_sig(0, 3000, 1'b0); chk(n, (r + 1) * LF * (1 << e));
    end
    rdr(4'h3); chk(rd[1:0], 2'h2);
    rdr(4'h3); chk(rd[1], 1'b0);
    wr(4'h2, 32'h7);
    rdr(4'h3); chk(rd[3], 1'b1);
    repeat (40) @(posedge CLK);
    rdr(4'h3); chk(rd[3], 1'b0);
    // Late service: cold reset with power-on pulse
    wr(4'h1, 32'h0);
    wr(4'h0, 32'h90);
    wr(4'h4, 3 + rnd(0) % 6);
    rdr(4'h3); chk(rd[5], 1'b1);
    wait_sig(1, 400, 1'b0);
    wait_sig(3, 40, 1'b0);
    stop_seq;
    rdr(4'h3); chk(rd[5:4], 2'h1);
    wait_sig(1, 300, 1'b1); chk(n, 300);
    wr(4'h3, 32'h10);
    rdr(4'h3); chk(rd[4], 1'b0);
    // Early service: warm reset stops the watchdog
    wr(4'h0, 32'h50);
    wr(4'h4, 32'h40);
    repeat (30) @(posedge CLK);
    wr(4'h4, 32'h40);
    wr(4'h4, 32'h40);
    wait_sig(2, 100, 1'b0);
    rdr(4'h3); chk(rd[5:4], 2'h1);
    RST_B <= 1'b0;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    rdr(4'h3); chk(rd[4], 1'b1);
    wr(4'h3, 32'h10);
    // Match mode: service byte, then a wrong byte
    wr(4'h0, 32'h70);
    wr(4'h4, 32'h40);
    rdr(4'h3); chk(rd[5], 1'b1);
    repeat (30) @(posedge CLK);
    wr(4'h5, 32'h5C);
    wait_sig(2, 20, 1'b1); chk(n, 20);
    rdr(4'h3); chk(rd[5], 1'b1);
    repeat (30) @(posedge CLK);
    wr(4'h5, 32'h11);
    wait_sig(2, 100, 1'b0);
    // Locks block writes until the unlock sequence
    wr(4'h0, 32'h03);
    wr(4'h0, 32'h20);
    wr(4'h1, 32'h3);
    stop_seq;
    rdr(4'h0); chk(rd[7:0], 8'h00);
    rdr(4'h1); chk(rd[2:0], 3'h0);
    // Late service clocked by terminal pulse, cold without power-on pulse
    wr(4'h2, 32'h3);
    wr(4'h3, 32'h1);
    wr(4'h0, 32'h00);
    wr(4'h4, 32'h03);
    wait_sig(1, 200, 1'b0);
    wait_sig(3, 40, 1'b1); chk(n, 40);
    end_sim;
  end
endmodule // twu_top_test
